// ### shared/dbi_map.vh
// Purpose : Constants for the data bus inversion controller.
// Assumes : Included by every design file of the block by bare name.
// Notes   : Widths are fixed; no registers are reachable by software.
`ifndef DBI_MAP_VH
`define DBI_MAP_VH
`define DBI_DATA_W     64
`define DBI_GROUP_W    16
`define DBI_GROUPS     4
`define DBI_BEATS      4
`define DBI_HALF_GROUP 5'h08
`define DBI_SYNC_W     2
`define DBI_GUARD_W    3
`endif

// ### hdl/dbi_group_coder.v
// Purpose : Inversion decision and data restore for one sixteen-bit group.
// Assumes : Bus lines are active low; inputs come from the same clock domain.
// Notes   : Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none
`include "dbi_map.vh"
module dbi_group_coder (
  input  wire [15:0] new_data,      // Data to send, true polarity
  input  wire [15:0] prev_lines,    // Levels of the group lines in the last beat
  input  wire [15:0] rx_lines,      // Captured group lines
  input  wire        rx_flag_n,     // Captured inversion flag, active low
  output wire [15:0] tx_lines,      // Levels to drive on the group lines
  output wire        tx_flag_n,     // Inversion flag to drive, active low
  output wire [15:0] rx_data        // Restored data, true polarity
);
  function [4:0] ones16;
    input [15:0] v;
    integer i;
    begin
      ones16 = 5'h00;
      for (i = 0; i < 16; i = i + 1) begin
        ones16 = ones16 + {4'h0, v[i]};
      end
    end
  endfunction
  // Plain encoding is the complement of the data, as the lines are active low.
  wire [15:0] plain_lines = ~new_data;
  wire        invert      = ones16(plain_lines ^ prev_lines) > `DBI_HALF_GROUP;
  assign tx_lines  = invert ? new_data : plain_lines;
  assign tx_flag_n = ~invert;
  // With the flag active the lines are read active high, otherwise active low.
  assign rx_data   = rx_flag_n ? ~rx_lines : rx_lines;
endmodule // dbi_group_coder
`default_nettype wire

// ### hdl/dbi_ctrl.v
// Purpose : Data bus inversion, busy, data valid and order_not_guaranteed_n handling for the data path.
// Assumes : Strobes and bus inputs arrive asynchronously and are synchronised
//           here; strobe edges are slow compared with clk.
// Notes   : Four beats make one burst; each beat is a strobe falling edge.
//           Our own strobes are kept away from the receiver until their echo
//           has left the synchronisers.
//
// Behaviour
// - Data splits into sixteen-bit groups, each with one active-low inversion flag.
// - Active flag means group is inverted and read active high.
// - Driver inverts a group when over half its bits would toggle.
// - Flags travel with data and are captured by the same strobes.
// - Driver asserts active-low busy while using the bus, frees it after.
// - Data is quad pumped, captured on falling edges of both strobes.
// - Driver asserts active-low data valid on each transfer.
`timescale 1ns/1ps
`default_nettype none
`include "dbi_map.vh"
module dbi_ctrl (
  input  wire        clk,                       // 20 MHz clock
  input  wire        reset,                     // Synchronous, active high
  input  wire        tx_start,                  // Pulse: begin a four-beat burst
  input  wire [255:0] tx_data,                  // Four beats, beat 0 in low bits
  output wire        tx_busy,                   // High while a burst is sent
  input  wire        beat_en,                   // Pulse: time for next outgoing beat
  output reg  [63:0] bus_data_o,                // Data lines out, active low
  output reg         bus_data_oe,               // Data lines driven
  input  wire [63:0] bus_data_i,                // Data lines in
  output reg  [3:0]  group_invert_flag_n_o,     // Inversion flags out
  output reg         group_invert_flag_n_oe,    // Flags driven
  input  wire [3:0]  group_invert_flag_n_i,     // Inversion flags in
  output reg  [3:0]  data_strobe_pos_n_o,       // Positive strobes out
  output reg  [3:0]  data_strobe_neg_n_o,       // Negative strobes out
  output reg         data_strobe_oe,            // Strobes driven
  input  wire [3:0]  data_strobe_pos_n_i,       // Positive strobes in
  input  wire [3:0]  data_strobe_neg_n_i,       // Negative strobes in
  output reg         data_bus_in_use_n_o,       // Busy out, active low
  output reg         data_bus_in_use_n_oe,      // Busy driven
  input  wire        data_bus_in_use_n_i,       // Busy in
  output reg         data_valid_n_o,            // Data valid out, active low
  output reg         data_valid_n_oe,           // Data valid driven
  input  wire        data_valid_n_i,            // Data valid in
  input  wire        order_not_guaranteed_n,    // Order_not_guaranteed_n in, active low
  output reg         order_not_guaranteed_n_seen,                // Level: order_not_guaranteed_n sampled active
  output reg  [63:0] rx_data,                   // Restored received beat
  output reg  [1:0]  rx_beat,                   // Index of received beat
  output reg         rx_valid,                  // Pulse: rx_data is new
  output wire        bus_free                   // Level: no agent holds the bus
);
  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  // Every bus input passes two flops before logic reads it. Data and flags
  // need no handshake: they settle long before the strobe edge that
  // qualifies them, and that edge waits in the same two flops.
  reg [63:0] d_s1_r;
  reg [63:0] d_s2_r;
  reg [3:0]  f_s1_r;
  reg [3:0]  f_s2_r;
  reg [3:0]  p_s1_r;
  reg [3:0]  p_s2_r;
  reg [3:0]  p_d_r;
  reg [3:0]  n_s1_r;
  reg [3:0]  n_s2_r;
  reg [3:0]  n_d_r;
  reg [2:0]  c_s1_r;
  reg [2:0]  c_s2_r;
  always @(posedge clk) begin
    if (reset) begin
      d_s1_r <= 64'h0;
      d_s2_r <= 64'h0;
      f_s1_r <= 4'hF;
      f_s2_r <= 4'hF;
      p_s1_r <= 4'hF;
      p_s2_r <= 4'hF;
      p_d_r  <= 4'hF;
      n_s1_r <= 4'hF;
      n_s2_r <= 4'hF;
      n_d_r  <= 4'hF;
      c_s1_r <= 3'h7;
      c_s2_r <= 3'h7;
    end else begin
      d_s1_r <= bus_data_i;
      d_s2_r <= d_s1_r;
      f_s1_r <= group_invert_flag_n_i;
      f_s2_r <= f_s1_r;
      p_s1_r <= data_strobe_pos_n_i;
      p_s2_r <= p_s1_r;
      p_d_r  <= p_s2_r;
      n_s1_r <= data_strobe_neg_n_i;
      n_s2_r <= n_s1_r;
      n_d_r  <= n_s2_r;
      c_s1_r <= {data_bus_in_use_n_i, data_valid_n_i, order_not_guaranteed_n};
      c_s2_r <= c_s1_r;
    end
  end
  // ------------------------------------------------------------
  // Transmit
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;
  reg  [1:0]   state_r;
  reg  [1:0]   beat_r;
  reg  [255:0] buf_r;
  wire [63:0]  tx_lines, rx_restored;
  wire [3:0]   tx_flags_n;
  wire [63:0]  cur_beat = buf_r[63:0];
  genvar g;
  generate
    for (g = 0; g < `DBI_GROUPS; g = g + 1) begin : grp
      dbi_group_coder u_coder (
        .new_data   (cur_beat[g*16 +: 16]),
        .prev_lines (bus_data_o[g*16 +: 16]),
        .rx_lines   (d_s2_r[g*16 +: 16]),
        .rx_flag_n  (f_s2_r[g]),
        .tx_lines   (tx_lines[g*16 +: 16]),
        .tx_flag_n  (tx_flags_n[g]),
        .rx_data    (rx_restored[g*16 +: 16])
      );
    end
  endgenerate
  assign tx_busy  = state_r == ST_SEND;
  assign bus_free = c_s2_r[2] & data_bus_in_use_n_o;
  always @(posedge clk) begin
    if (reset) begin
      state_r                <= ST_IDLE;
      beat_r                 <= 2'h0;
      buf_r                  <= 256'h0;
      bus_data_o             <= 64'hFFFFFFFFFFFFFFFF;
      bus_data_oe            <= 1'b0;
      group_invert_flag_n_o  <= 4'hF;
      group_invert_flag_n_oe <= 1'b0;
      data_strobe_pos_n_o    <= 4'hF;
      data_strobe_neg_n_o    <= 4'hF;
      data_strobe_oe         <= 1'b0;
      data_bus_in_use_n_o    <= 1'b1;
      data_bus_in_use_n_oe   <= 1'b0;
      data_valid_n_o         <= 1'b1;
      data_valid_n_oe        <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          data_bus_in_use_n_o    <= 1'b1;
          data_valid_n_o         <= 1'b1;
          bus_data_oe            <= 1'b0;
          group_invert_flag_n_oe <= 1'b0;
          data_strobe_oe         <= 1'b0;
          data_valid_n_oe        <= 1'b0;
          data_bus_in_use_n_oe   <= 1'b0;
          data_strobe_pos_n_o    <= 4'hF;
          data_strobe_neg_n_o    <= 4'hF;
          // Released lines float to their pull-up level, so the first beat
          // of the next burst is judged against all lines high.
          bus_data_o             <= 64'hFFFFFFFFFFFFFFFF;
          group_invert_flag_n_o  <= 4'hF;
          // Wait until the other agent has released the bus.
          if (tx_start && c_s2_r[2]) begin
            buf_r <= tx_data;
            beat_r <= 2'h0;
            state_r <= ST_SEND;
            data_bus_in_use_n_o  <= 1'b0;
            data_bus_in_use_n_oe <= 1'b1;
            data_valid_n_oe <= 1'b1;
          end
        end
        ST_SEND: begin
          if (beat_en) begin
            bus_data_o <= tx_lines;
            group_invert_flag_n_o <= tx_flags_n;
            bus_data_oe <= 1'b1;
            group_invert_flag_n_oe <= 1'b1;
            data_strobe_oe <= 1'b1;
            data_valid_n_o <= 1'b0;
            // Even beats ride the positive strobe, odd the negative.
            data_strobe_pos_n_o <= beat_r[0] ? 4'hF : 4'h0;
            data_strobe_neg_n_o <= beat_r[0] ? 4'h0 : 4'hF;
            buf_r <= {64'h0, buf_r[255:64]};
            beat_r <= beat_r + 2'h1;
            if (beat_r == 2'h3) state_r <= ST_IDLE;
          end else begin
            data_strobe_pos_n_o <= 4'hF;
            data_strobe_neg_n_o <= 4'hF;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Receive
  // ------------------------------------------------------------
  // A falling edge on either strobe of group 0 marks a beat; the other
  // groups are assumed to be skew-matched within one clk period.
  // Our own last strobes come back through the synchronisers after busy is
  // already released; a short history of the strobe enable hides that echo.
  reg  [`DBI_GUARD_W-1:0] own_hist_r;
  reg  [1:0]              rx_cnt_r;
  wire                    own_echo = data_strobe_oe | (|own_hist_r);
  wire cap = ((p_d_r[0] & ~p_s2_r[0]) | (n_d_r[0] & ~n_s2_r[0]))
             & ~c_s2_r[1] & data_bus_in_use_n_o & ~own_echo;
  always @(posedge clk) begin
    if (reset) begin
      own_hist_r <= {`DBI_GUARD_W{1'b0}};
      rx_cnt_r   <= 2'h0;
      rx_data    <= 64'h0;
      rx_beat    <= 2'h0;
      rx_valid   <= 1'b0;
      order_not_guaranteed_n_seen <= 1'b0;
    end else begin
      own_hist_r <= {own_hist_r[`DBI_GUARD_W-2:0], data_strobe_oe};
      rx_valid   <= cap;
      order_not_guaranteed_n_seen <= ~c_s2_r[0];
      if (cap) begin
        rx_data  <= rx_restored;
        // The index reported is that of the beat now in rx_data.
        rx_beat  <= rx_cnt_r;
        rx_cnt_r <= rx_cnt_r + 2'h1;
      end
      // Each new owner of the bus starts again at beat zero.
      if (c_s2_r[2]) rx_cnt_r <= 2'h0;
    end
  end
endmodule // dbi_ctrl
`default_nettype wire

// ### verification/dbi_ctrl_monitor.sv
// Purpose: Port assertions for the inversion controller.
// Assumes: Bound to every dbi_ctrl instance.
// Notes: The toggle limit is judged against the line levels of the beat before.
`timescale 1ns/1ps
`default_nettype none
module dbi_ctrl_monitor (
  input wire logic        clk,                    // Clock
  input wire logic        reset,                  // Reset
  input wire logic        tx_start,               // Start
  input wire logic        tx_busy,                // Sending
  input wire logic        beat_en,                // Beat
  input wire logic [63:0] bus_data_o,             // Lines
  input wire logic [3:0]  group_invert_flag_n_o,  // Flags
  input wire logic [3:0]  data_strobe_pos_n_o,    // Strobes
  input wire logic [3:0]  data_strobe_neg_n_o,    // Strobes
  input wire logic        data_bus_in_use_n_o,    // Busy
  input wire logic        data_bus_in_use_n_oe,   // Busy on
  input wire logic        data_bus_in_use_n_i,    // Busy in
  input wire logic        data_valid_n_o,         // Valid
  input wire logic        order_not_guaranteed_n, // Order_not_guaranteed_n
  input wire logic        order_not_guaranteed_n_seen,             // Order_not_guaranteed_n seen
  input wire logic        bus_free                // Free
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // An inverted group must toggle fewer lines than a plain one may.
  function automatic bit calm(input logic [63:0] l, p, input logic [3:0] f);
    calm = 1'b1;
    for (int g = 0; g < 4; g++)
      if ($countones(l[16*g+:16] ^ p[16*g+:16]) > (f[g] ? 8 : 7)) calm = 1'b0;
  endfunction
  sequence s_beat; beat_en && tx_busy; endsequence
  sequence s_out; !data_valid_n_o ##0 (data_strobe_pos_n_o[0] ^ data_strobe_neg_n_o[0]); endsequence
  property p_start;
    tx_start && bus_free && !tx_busy |=> !data_bus_in_use_n_o && data_bus_in_use_n_oe;
  endproperty
  a_start: assert property (p_start) else $error("busy not raised");
  property p_beat; s_beat |=> s_out; endproperty
  a_beat: assert property (p_beat) else $error("beat not marked");
  property p_code; s_beat |=> calm(bus_data_o, $past(bus_data_o), group_invert_flag_n_o); endproperty
  a_code: assert property (p_code) else $error("inversion choice wrong");
  property p_pulse; !data_strobe_pos_n_o[0] |=> data_strobe_pos_n_o[0]; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  property p_hold; !data_valid_n_o |-> !data_bus_in_use_n_o; endproperty
  a_hold: assert property (p_hold) else $error("valid without busy");
  property p_end; $fell(tx_busy) |-> ##[0:1] data_bus_in_use_n_o; endproperty
  a_end: assert property (p_end) else $error("busy not released");
  property p_order_not_guaranteed_n; !order_not_guaranteed_n [*4] |-> order_not_guaranteed_n_seen; endproperty
  a_order_not_guaranteed_n: assert property (p_order_not_guaranteed_n) else $error("order_not_guaranteed_n missed");
  // Free may only be reported once the busy line was seen high two edges ago.
  property p_free; bus_free |-> $past(data_bus_in_use_n_i, 2); endproperty
  a_free: assert property (p_free) else $error("free while busy");
endmodule // dbi_ctrl_monitor
bind dbi_ctrl dbi_ctrl_monitor mon_u (.clk, .reset, .tx_start, .tx_busy, .beat_en, .bus_data_o,
  .group_invert_flag_n_o, .data_strobe_pos_n_o, .data_strobe_neg_n_o, .data_bus_in_use_n_o,
  .data_bus_in_use_n_oe, .data_bus_in_use_n_i, .data_valid_n_o, .order_not_guaranteed_n,
  .order_not_guaranteed_n_seen, .bus_free);
`default_nettype wire

// ### verification/dbi_far_model.sv
// Purpose: Far agent that drives received beats onto the shared lines.
// Assumes: Lines are pulled up, so released lines read high.
// Notes: Strobes stand still between frames; link period is 400 ns.
`timescale 1ns/1ps
`default_nettype none
module dbi_far_model (
  output logic [63:0] dat, // Data lines
  output logic [3:0]  flg, // Flags
  output logic [3:0]  stp, // Positive strobes
  output logic [3:0]  stn, // Negative strobes
  output logic        bsy, // Busy
  output logic        vld  // Valid
);
  initial {dat, flg, stp, stn, bsy, vld} = '1;
  task automatic beat(input logic [63:0] d, input logic [3:0] f, input bit odd, input bit last);
    {bsy, vld, dat, flg} = {2'b00, d, f};
    #200;
    if (odd) stn = 4'h0;
    else stp = 4'h0;
    #200;
    {stp, stn} = '1;
    if (last) {bsy, vld, dat, flg} = '1;
  endtask
endmodule // dbi_far_model
`default_nettype wire

// ### verification/dbi_ctrl_tb_top.sv
// Purpose: Self-checking bench for dbi_ctrl.
// Assumes: Shared lines resolve as pulled-up wires driven by either side.
// Notes: Inputs change 5 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module dbi_ctrl_tb_top;
  logic clk, reset, tx_start, beat_en, order_not_guaranteed_n;
  logic [255:0] tx_data;
  wire tx_busy, bus_data_oe, group_invert_flag_n_oe, data_strobe_oe, data_bus_in_use_n_o;
  wire data_bus_in_use_n_oe, data_bus_in_use_n_i, data_valid_n_o, data_valid_n_oe;
  wire data_valid_n_i, order_not_guaranteed_n_seen, rx_valid, bus_free, m_bsy, m_vld;
  wire [63:0] bus_data_o, bus_data_i, rx_data, m_dat;
  wire [3:0] group_invert_flag_n_o, group_invert_flag_n_i, data_strobe_pos_n_o, m_flg;
  wire [3:0] data_strobe_neg_n_o, data_strobe_pos_n_i, data_strobe_neg_n_i, m_stp, m_stn;
  wire [1:0] rx_beat;
  int errors = 0;
  int cmp_count = 0;
  // Row: expected flags of beats 3..0, then beats 3..0 of data.
  logic [271:0] rows [2] = '{{16'hF0FC, 64'hFE00, {4{16'hFFFF}}, 64'h0, 64'h00FF_01FF_FFFF},
                            {16'hFFF0, 192'h0, {4{16'hFFFF}}}};
  assign bus_data_i = (bus_data_oe ? bus_data_o : '1) & m_dat;
  assign group_invert_flag_n_i = (group_invert_flag_n_oe ? group_invert_flag_n_o : '1) & m_flg;
  assign data_strobe_pos_n_i = (data_strobe_oe ? data_strobe_pos_n_o : '1) & m_stp;
  assign data_strobe_neg_n_i = (data_strobe_oe ? data_strobe_neg_n_o : '1) & m_stn;
  assign data_bus_in_use_n_i = (data_bus_in_use_n_oe ? data_bus_in_use_n_o : 1'b1) & m_bsy;
  assign data_valid_n_i = (data_valid_n_oe ? data_valid_n_o : 1'b1) & m_vld;
  dbi_ctrl dut_u (.*);
  dbi_far_model far_u (.dat(m_dat), .flg(m_flg), .stp(m_stp), .stn(m_stn), .bsy(m_bsy), .vld(m_vld));
  task automatic chk(input logic [67:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic burst(input logic [271:0] r);
    logic [63:0] d;
    // The block refuses a start until it has seen the bus released.
    while (bus_free !== 1'b1) tick();
    tx_data = r[255:0];
    tx_start = 1'b1;
    tick();
    {tx_start, beat_en} = 2'b01;
    chk(data_bus_in_use_n_o, 0);
    for (int b = 0; b < 4; b++) begin
      tick();
      tx_start = (b == 1);
      beat_en = (b != 3);
      d = ~r[64*b+:64];
      for (int g = 0; g < 4; g++) if (!r[256+4*b+g]) d[16*g+:16] = ~d[16*g+:16];
      chk({group_invert_flag_n_o, bus_data_o}, {r[256+4*b+:4], d});
    end
    tick(2);
    chk({tx_busy, data_bus_in_use_n_o}, 2'b01);
  endtask
  task automatic rx_wait(input logic [1:0] idx);
    int n = 0;
    while (rx_valid !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    chk({rx_beat, rx_data}, {idx, 64'hEDCB_5678_6543_DEF0});
    tick();
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end
  initial begin
    {reset, order_not_guaranteed_n, tx_start, beat_en, tx_data} = {2'b11, 258'h0};
    tick(20);
    chk({bus_data_oe, data_bus_in_use_n_o, bus_data_o}, {2'b01, 64'hFFFF_FFFF_FFFF_FFFF});
    reset = 1'b0;
    tick(2);
    foreach (rows[i]) burst(rows[i]);
    fork
      begin
        far_u.beat(64'h1234_5678_9ABC_DEF0, 4'hA, 1'b0, 1'b0);
        far_u.beat(64'hEDCB_A987_6543_210F, 4'h5, 1'b1, 1'b1);
      end
      begin
        rx_wait(2'h0);
        rx_wait(2'h1);
      end
      begin
        // A start request while the far agent holds the bus is refused.
        tick(4);
        tx_start = 1'b1;
        tick();
        tx_start = 1'b0;
        chk(tx_busy, 1'b0);
      end
    join
    order_not_guaranteed_n = 1'b0;
    tick(5);
    chk(order_not_guaranteed_n_seen, 1'b1);
    order_not_guaranteed_n = 1'b1;
    tick(5);
    chk(order_not_guaranteed_n_seen, 1'b0);
    tally_and_finish();
  end
endmodule // dbi_ctrl_tb_top
`default_nettype wire
